/* pkg/key_scan_params.svh */
`ifndef KEY_SCAN_PARAMS_SVH
`define KEY_SCAN_PARAMS_SVH

// instruction cycle timing
`define KS_INSTR_TIME_NS   44400
`define KS_CLK_PERIOD_NS   50
`define KS_INSTR_CYCLES    (`KS_INSTR_TIME_NS / `KS_CLK_PERIOD_NS)

// digit scan geometry: digit, slot and sample counts, slot timing in instruction cycles
`define KS_DIGITS          7
`define KS_SLOT_INSTR      5
`define KS_SCAN_SLOTS      8
`define KS_SAMPLE_INSTR    3'h2
`define KS_CHECK_SAMPLES   3'h6

// operand port codes
`define KS_CN_RESULT_LO    3'h0
`define KS_CN_RESULT_HI    3'h1
`define KS_CN_LATCH        3'h2
`define KS_CN_BLANK        3'h4
`define KS_CN_STATUS       3'h5
`define KS_CN_SELECT_LO    3'h6
`define KS_CN_SELECT_HI    3'h7

// field positions
`define KS_BLANK_BIT       0
`define KS_KEYRST_BIT      2
`define KS_STAT_K0_BIT     0
`define KS_STAT_ON_BIT     1

// reset values
`define KS_BLANK_RST       1'b0
`define KS_SELECT_RST      7'h00

`endif

/* pkg/key_scan_pkg.sv */
package key_scan_pkg;

  typedef enum logic [1:0] {
    scan_idle,
    scan_sample,
    scan_check
  } scan_mode_type;

  typedef struct packed {
    logic [3:0]    sync_a;
    logic [3:0]    sync_b;
    logic [15:0]   div_cnt;
    logic [2:0]    slot_instr;
    logic [2:0]    digit_idx;
    scan_mode_type mode;
    logic [2:0]    samples;
    logic [3:0]    latch;
    logic [6:0]    result;
    logic [6:0]    select;
    logic          blank;
    logic          key_present;
    logic [6:0]    digit_out;
    logic [7:0]    seg_out;
    logic [3:0]    rd_data;
    logic          rd_valid;
    logic          wake;
  } state_type;

endpackage : key_scan_pkg

/* design/key_matrix_scan.sv */
`timescale 1ns/100ps
`include "key_scan_params.svh"

module key_matrix_scan
  import key_scan_pkg::*;
#(
  parameter int INSTR_CYCLES = `KS_INSTR_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       backup_mode,
  input  wire logic       clock_halt_instr,
  input  wire logic       io_out_stb,
  input  wire logic       io_in_stb,
  input  wire logic       key_out_stb,
  input  wire logic       key_in_stb,
  input  wire logic [2:0] operand_port_code,
  input  wire logic [3:0] wr_data,
  output logic      [3:0] rd_data,
  output logic            rd_valid,
  input  wire logic [3:0] key_in_lines,
  input  wire logic [7:0] seg_pattern,
  output logic      [6:0] digit_strobe_lines,
  output logic      [7:0] segment_lines,
  output logic            wait_release
);

  // divider counter is 16 bits wide and needs at least two clocks per tick
  initial begin
    if (INSTR_CYCLES < 2 || INSTR_CYCLES > 65535) begin
      $error("INSTR_CYCLES out of range");
    end
  end

  localparam logic [15:0] DIV_LAST = 16'(INSTR_CYCLES - 1);
  localparam logic [2:0]  SLOT_LAST = 3'(`KS_SLOT_INSTR - 1);
  localparam logic [2:0]  IDX_LAST = 3'(`KS_SCAN_SLOTS - 1);
  localparam logic [2:0]  IDX_BLANK = 3'(`KS_DIGITS);

  // one-hot digit select for a scan slot; the blank slot gives none
  function automatic logic [6:0] digit_onehot(input logic [2:0] idx);
    logic [6:0] v;
    v = 7'h00;
    if (idx < IDX_BLANK) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction : digit_onehot

  state_type s_q;
  state_type s_d;

  logic       instr_tick;
  logic       outputs_on;
  logic       sample_pulse;
  logic [6:0] cur_digit;
  logic       any_key;
  logic       key_reset_wr;

  // scan timing and decode helpers
  always_comb begin
    instr_tick = (s_q.div_cnt == DIV_LAST);
    // blanking or backup holds the digits low, so the matrix is never
    // strobed and sampling must stop too
    outputs_on = !s_q.blank && !backup_mode;
    cur_digit = digit_onehot(s_q.digit_idx);
    sample_pulse = instr_tick && outputs_on && (cur_digit != 7'h00)
                   && (s_q.slot_instr == `KS_SAMPLE_INSTR);
    // open matrix positions read low thanks to pull-downs
    any_key = (s_q.sync_b != 4'h0);
    key_reset_wr = io_out_stb && (operand_port_code == `KS_CN_STATUS)
                   && wr_data[`KS_KEYRST_BIT];
  end

  // whole next-state function
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;
    s_d.rd_valid = 1'b0;

    // key lines come from pins: two flops before any use
    s_d.sync_a = key_in_lines;
    s_d.sync_b = s_q.sync_a;

    // instruction-cycle divider, then 5 instructions per slot, 8 slots
    if (instr_tick) begin
      s_d.div_cnt = 16'h0000;
      if (s_q.slot_instr == SLOT_LAST) begin
        s_d.slot_instr = 3'h0;
        // seven digit slots plus one idle slot make the 40 cycle period
        s_d.digit_idx = (s_q.digit_idx == IDX_LAST) ? 3'h0
                        : 3'(s_q.digit_idx + 3'h1);
      end else begin
        s_d.slot_instr = 3'(s_q.slot_instr + 3'h1);
      end
    end else begin
      s_d.div_cnt = 16'(s_q.div_cnt + 16'h0001);
    end

    // digit and segment drivers
    if (outputs_on) begin
      s_d.digit_out = cur_digit;
      s_d.seg_out = (cur_digit != 7'h00) ? seg_pattern : 8'h00;
    end else begin
      s_d.digit_out = 7'h00;
      s_d.seg_out = 8'h00;
    end

    // cpu writes; other ports survive a clock halt instruction, only blank is cleared
    if (key_out_stb && operand_port_code == `KS_CN_BLANK) begin
      s_d.blank = wr_data[`KS_BLANK_BIT];
    end
    if (clock_halt_instr) begin
      s_d.blank = `KS_BLANK_RST;
    end
    if (io_out_stb && operand_port_code == `KS_CN_SELECT_LO) begin
      s_d.select[3:0] = wr_data;
    end
    if (io_out_stb && operand_port_code == `KS_CN_SELECT_HI) begin
      s_d.select[6:4] = wr_data[2:0];
    end

    // key reset restarts sampling and drops the flag
    if (key_reset_wr) begin
      s_d.mode = scan_sample;
      s_d.key_present = 1'b0;
    end

    // capture and return-line check
    case (s_q.mode)
      scan_sample: begin
        // only digits enabled in the select port may capture
        if (sample_pulse && any_key
            && ((cur_digit & s_q.select) != 7'h00)) begin
          s_d.latch = s_q.sync_b;
          // the capturing line already shows a key, so it counts as checked
          s_d.result = cur_digit & s_q.select;
          s_d.samples = 3'h0;
          s_d.mode = scan_check;
        end
      end
      scan_check: begin
        if (sample_pulse) begin
          // deselected lines never get a result bit
          if (any_key) begin
            s_d.result = s_q.result
                         | (cur_digit & s_q.select);
          end
          s_d.samples = 3'(s_q.samples + 3'h1);
          // six further samples cover every other line: 35 instruction cycles
          // across the idle slot, but 30 when the capture was on digit 0
          if (s_q.samples == 3'(`KS_CHECK_SAMPLES - 3'h1)) begin
            // a key reset in the same cycle loses: the set wins
            s_d.key_present = 1'b1;
            s_d.mode = scan_idle;
            s_d.wake = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase

    // cpu reads, answered one cycle after the strobe
    if (io_in_stb) begin
      s_d.rd_valid = 1'b1;
      if (operand_port_code == `KS_CN_STATUS) begin
        s_d.rd_data = 4'h0;
        s_d.rd_data[`KS_STAT_K0_BIT] = s_q.sync_b[0];
        s_d.rd_data[`KS_STAT_ON_BIT] = s_q.key_present;
      end else if (operand_port_code == `KS_CN_SELECT_LO) begin
        s_d.rd_data = s_q.select[3:0];
      end else if (operand_port_code == `KS_CN_SELECT_HI) begin
        s_d.rd_data = {1'b0, s_q.select[6:4]};
      end else begin
        s_d.rd_data = 4'h0;
      end
    end else if (key_in_stb) begin
      s_d.rd_valid = 1'b1;
      if (operand_port_code == `KS_CN_LATCH) begin
        s_d.rd_data = s_q.latch;
      end else if (operand_port_code == `KS_CN_RESULT_LO) begin
        s_d.rd_data = s_q.result[3:0] & s_q.select[3:0];
      end else if (operand_port_code == `KS_CN_RESULT_HI) begin
        s_d.rd_data = {1'b0, s_q.result[6:4] & s_q.select[6:4]};
      end else begin
        s_d.rd_data = 4'h0;
      end
    end
  end

  // single state register; reset leaves every driver low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q.sync_a      <= 4'h0;
      s_q.sync_b      <= 4'h0;
      s_q.div_cnt     <= 16'h0000;
      s_q.slot_instr  <= 3'h0;
      s_q.digit_idx   <= 3'h0;
      s_q.mode        <= scan_idle;
      s_q.samples     <= 3'h0;
      s_q.latch       <= 4'h0;
      s_q.result      <= 7'h00;
      s_q.select      <= `KS_SELECT_RST;
      s_q.blank       <= `KS_BLANK_RST;
      s_q.key_present <= 1'b0;
      s_q.digit_out   <= 7'h00;
      s_q.seg_out     <= 8'h00;
      s_q.rd_data     <= 4'h0;
      s_q.rd_valid    <= 1'b0;
      s_q.wake        <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from the state flops
  assign digit_strobe_lines = s_q.digit_out;
  assign segment_lines      = s_q.seg_out;
  assign rd_data            = s_q.rd_data;
  assign rd_valid           = s_q.rd_valid;
  assign wait_release       = s_q.wake;

endmodule : key_matrix_scan

/* tb/key_matrix_model.sv */
`timescale 1ns/100ps
// switch matrix: a closed switch ties its key line to its digit line
module key_matrix_model (
  input  wire logic [6:0]  digit_strobe_lines,
  input  wire logic [27:0] pressed,
  output logic      [3:0]  key_in_lines
);
  // open positions fall to the pull-down level, never float
  always_comb begin
    key_in_lines = 4'h0;
    for (int d = 0; d < 7; d++) begin
      key_in_lines |= pressed[d*4 +: 4] & {4{digit_strobe_lines[d]}};
    end
  end
endmodule : key_matrix_model

/* tb/key_matrix_scan_props.sv */
`timescale 1ns/100ps
module key_matrix_scan_chk #(
  parameter int INSTR_CYCLES = 4
) (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       backup_mode,
  input wire logic       io_out_stb,
  input wire logic       io_in_stb,
  input wire logic       key_out_stb,
  input wire logic       key_in_stb,
  input wire logic [2:0] operand_port_code,
  input wire logic [3:0] wr_data,
  input wire logic [3:0] rd_data,
  input wire logic       rd_valid,
  input wire logic [3:0] key_in_lines,
  input wire logic [6:0] digit_strobe_lines,
  input wire logic [7:0] segment_lines,
  input wire logic       wait_release
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [15:0] since_q;
  sequence k0_steady;
    key_in_lines[0] [*4];
  endsequence
  sequence status_rd;
    io_in_stb && operand_port_code == 3'h5;
  endsequence
  // clocks since the last key reset, saturating so it never wraps
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) since_q <= 16'h0;
    else if (io_out_stb && operand_port_code == 3'h5 && wr_data[2])
      since_q <= 16'h0;
    else if (since_q != 16'hffff) since_q <= since_q + 16'h1;
  end
  a_blank_dark: assert property (
    key_out_stb && operand_port_code == 3'h4 && wr_data[0] |-> ##3
    (digit_strobe_lines == 7'h0 && segment_lines == 8'h0) [*8])
    else $error("display lit after blank write");
  a_backup_dark: assert property (
    backup_mode |=> digit_strobe_lines == 7'h0 && segment_lines == 8'h0)
    else $error("display lit in backup");
  a_one_digit: assert property ($onehot0(digit_strobe_lines))
    else $error("two digits lit together");
  a_seg_gated: assert property (
    digit_strobe_lines == 7'h0 |-> segment_lines == 8'h0)
    else $error("segments lit with no digit");
  a_rd_pulse: assert property (
    rd_valid == $past(io_in_stb || key_in_stb))
    else $error("read valid not one cycle after strobe");
  a_wake_pulse: assert property (wait_release |=> !wait_release)
    else $error("wake pulse too long");
  a_k0_live: assert property (k0_steady ##0 status_rd |=> rd_data[0])
    else $error("live key line not reported");
  a_flag_late: assert property (
    wait_release |-> since_q >= 16'(35 * INSTR_CYCLES))
    else $error("key present set too early");
endmodule : key_matrix_scan_chk

bind key_matrix_scan key_matrix_scan_chk #(.INSTR_CYCLES(INSTR_CYCLES))
  u_key_matrix_scan_chk (.*);

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic        clock, rstn, backup_mode, clock_halt_instr;
  logic        io_out_stb, io_in_stb, key_out_stb, key_in_stb;
  logic [2:0]  operand_port_code;
  logic [3:0]  wr_data, rd_data, key_in_lines, rdv;
  logic        rd_valid, wait_release;
  logic [7:0]  seg_pattern, segment_lines;
  logic [6:0]  digit_strobe_lines;
  logic [27:0] pressed;
  int          fails, checks, cyc, n;

  key_matrix_scan #(.INSTR_CYCLES(4)) u_key_matrix_scan (.*);
  key_matrix_model u_key_matrix_model (.*);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // a hang is cut at 8000 cycles; the tests need about 1600
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // s = {key in, key out, io in, io out}; strobe stands one cycle
  task automatic op(input logic [3:0] s, input logic [2:0] c,
                    input logic [3:0] d);
    @(posedge clock);
    #5 {key_in_stb, key_out_stb, io_in_stb, io_out_stb} = s;
    operand_port_code = c;
    wr_data = d;
    @(posedge clock);
    #5 {key_in_stb, key_out_stb, io_in_stb, io_out_stb} = 4'h0;
    rdv = rd_data;
    if (s[3] | s[1]) cmp({7'h0, rd_valid}, 8'h01);
  endtask
  task automatic rd(input logic [3:0] s, input logic [2:0] c,
                    input logic [7:0] e);
    op(s, c, 4'h0);
    cmp({4'h0, rdv}, e);
  endtask
  // clocks from the key reset to the wake pulse, worst case near 300
  task automatic wake();
    n = 0;
    while (wait_release !== 1'b1 && n < 400) begin
      @(posedge clock);
      #5 n++;
    end
    cmp({7'h0, n >= 140 && n <= 330}, 8'h01);
  endtask
  task automatic lit();
    n = 0;
    repeat (200) begin
      @(posedge clock);
      #5 n += int'(digit_strobe_lines != 7'h0);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {rstn, backup_mode, clock_halt_instr} = 3'h0;
    {io_out_stb, io_in_stb, key_out_stb, key_in_stb} = 4'h0;
    operand_port_code = 3'h0;
    wr_data = 4'h0;
    seg_pattern = 8'ha5;
    pressed = 28'h0801200;
    fails = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge clock);
    #5 rstn = 1'b1;
    rd(4'h2, 3'h6, 8'h00);
    rd(4'h8, 3'h2, 8'h00);
    op(4'h1, 3'h6, 4'h4);
    op(4'h1, 3'h7, 4'hf);
    rd(4'h2, 3'h7, 8'h07);
    op(4'h1, 3'h7, 4'h0);
    rd(4'h2, 3'h6, 8'h04);
    $display("test select done");
    // digit 2 selected; keys on deselected digits 3 and 5 must not count
    op(4'h1, 3'h5, 4'h4);
    wake();
    rd(4'h8, 3'h2, 8'h02);
    rd(4'h8, 3'h0, 8'h04);
    rd(4'h8, 3'h1, 8'h00);
    wait (digit_strobe_lines[3] === 1'b1);
    repeat (4) @(posedge clock);
    rd(4'h2, 3'h5, 8'h03);
    wait (digit_strobe_lines[3] === 1'b0);
    repeat (4) @(posedge clock);
    rd(4'h2, 3'h5, 8'h02);
    pressed = 28'h0800400;
    repeat (170) @(posedge clock);
    rd(4'h8, 3'h2, 8'h02);
    op(4'h1, 3'h5, 4'h0);
    rd(4'h2, 3'h5, 8'h02);
    op(4'h1, 3'h5, 4'h4);
    rd(4'h2, 3'h5, 8'h00);
    wake();
    rd(4'h8, 3'h2, 8'h04);
    $display("test capture done");
    op(4'h4, 3'h4, 4'h1);
    op(4'h1, 3'h5, 4'h4);
    repeat (3) @(posedge clock);
    lit();
    cmp(8'(n), 8'h00);
    rd(4'h2, 3'h5, 8'h00);
    op(4'h4, 3'h4, 4'h0);
    wake();
    op(4'h4, 3'h4, 4'h1);
    repeat (12) @(posedge clock);
    #5 clock_halt_instr = 1'b1;
    @(posedge clock);
    #5 clock_halt_instr = 1'b0;
    lit();
    cmp({7'h0, n > 0}, 8'h01);
    backup_mode = 1'b1;
    @(posedge clock);
    lit();
    cmp(8'(n), 8'h00);
    backup_mode = 1'b0;
    rd(4'h2, 3'h6, 8'h04);
    $display("test blank done");
    print_verdict();
  end
endmodule : tb_top
